// ### dv/arcs_node_model.sv
// remote serial-bus node model: ack codes to the transmit units and lock requests
`include "arcs_consts.svh"
module arcs_node_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// acks towards the transmit units
	output arcs_pkg::arcs_ack_t [`ARCS_NUM_UNITS-1:0] txAck,
	// lock requests and answers
	output arcs_pkg::arcs_lock_req_t remoteLock,
	input wire arcs_pkg::arcs_lock_rsp_t remoteRsp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		txAck = '0;
		remoteLock = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one-cycle ack pulse; code lines scrambled once released
	task automatic send_ack(input int u, input logic [3:0] code);
		@(posedge core_clk);
		txAck[u] <= '{valid: 1'b1, code: code};
		@(posedge core_clk);
		txAck[u] <= '{valid: 1'b0, code: ~code};
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// lock held until the ack edge, then dropped with inverted payload
	task automatic do_lock(input arcs_pkg::arcs_sel_t s, input logic [31:0] cmp,
			input logic [31:0] nv, output logic [31:0] old, output logic ok);
		int n;
		@(posedge core_clk);
		remoteLock <= '{valid: 1'b1, sel: s, compare: cmp, newValue: nv};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (remoteRsp.ack !== 1'b1 && n < 50);
		old = remoteRsp.oldValue;
		ok = (n < 50);
		remoteLock <= '{valid: 1'b0, sel: s, compare: ~cmp, newValue: ~nv};
	endtask
endmodule

// ### dv/arcs_regs_tb.sv
// self-checking bench for the retry and compare-swap register bank
`include "arcs_consts.svh"
module arcs_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic coreClk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h00000000;
	logic [3:0] avsByteenable = 4'hF;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic [2:0] txStart = 3'h0;
	logic [2:0] txResend;
	logic [2:0] txGiveUp;
	arcs_pkg::arcs_ack_t [2:0] txAck;
	arcs_pkg::arcs_lock_req_t remoteLock;
	arcs_pkg::arcs_lock_rsp_t remoteRsp;
	logic irq;
	logic [31:0] rd;
	int errTotal = 0;
	int nCompared = 0;
	int cycles = 0;
	arcs_regs i_arcs_regs (.core_clk(coreClk), .rst(rst), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
		.avs_waitrequest(avsWaitrequest), .txStart(txStart), .txAck(txAck),
		.txResend(txResend), .txGiveUp(txGiveUp), .remoteLock(remoteLock),
		.remoteRsp(remoteRsp), .irq(irq));
	arcs_node_model i_arcs_node_model (.core_clk(coreClk), .rst(rst), .txAck(txAck),
		.remoteLock(remoteLock), .remoteRsp(remoteRsp));
	always #2 coreClk = ~coreClk;
	always @(posedge coreClk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			$display("Error at %0t: run timed out", $time);
			wrapUp();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// shared checks and bus cycles
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		nCompared++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int n;
		@(posedge coreClk);
		avsAddress <= a;
		avsRead <= !wr;
		avsWrite <= wr;
		avsWritedata <= d;
		avsByteenable <= be;
		n = 0;
		do begin
			@(posedge coreClk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 50);
		rd = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		if (n >= 50) begin
			errTotal++;
			$display("Error at %0t: bus answer missing", $time);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h00000000, 4'hF);
		chk(rd, exp, what);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic test_reset();
		rreg(`ARCS_OFF_RETRY, 32'h00000000, "retry after reset");
		rreg(`ARCS_OFF_CTRL, 32'h80000000, "control after reset");
		$display("test reset done");
	endtask
	task automatic test_retry_reg();
		wreg(`ARCS_OFF_RETRY, 32'hFFFFFFFF);
		rreg(`ARCS_OFF_RETRY, 32'h00000FFF, "retry ro bits");
		wreg(`ARCS_OFF_RETRY, 32'h00000A00);
		rreg(`ARCS_OFF_RETRY, 32'h00000A00, "phys field");
		wreg(`ARCS_OFF_RETRY, 32'h000000B0);
		rreg(`ARCS_OFF_RETRY, 32'h000000B0, "resp field");
		wreg(`ARCS_OFF_RETRY, 32'h0000000C);
		rreg(`ARCS_OFF_RETRY, 32'h0000000C, "req field");
		bus(1'b1, `ARCS_OFF_RETRY, 32'hFFFFFFFF, 4'h2);
		rreg(`ARCS_OFF_RETRY, 32'h00000F0C, "lane one only");
		wreg(8'h30, 32'hFFFFFFFF);
		rreg(8'h30, 32'h00000000, "unmapped read");
		$display("test retry register done");
	endtask
	task automatic test_swap();
		for (int s = 0; s < 4; s++) begin
			wreg(`ARCS_OFF_NEWVAL, 32'h10000000 + 32'(s));
			wreg(`ARCS_OFF_CMPVAL, 32'h00000000);
			wreg(`ARCS_OFF_CTRL, 32'hFFFFFFFC | 32'(s));
			rreg(`ARCS_OFF_CTRL, 32'h80000000 | 32'(s), "control");
			rreg(`ARCS_OFF_NEWVAL, 32'h00000000, "old value");
			wreg(`ARCS_OFF_NEWVAL, 32'h20000000 + 32'(s));
			wreg(`ARCS_OFF_CMPVAL, 32'hFFFFFFFF);
			wreg(`ARCS_OFF_CTRL, 32'(s));
			rreg(`ARCS_OFF_NEWVAL, 32'h10000000 + 32'(s), "swapped");
			rreg(`ARCS_OFF_CTRL, 32'h80000000 | 32'(s), "done again");
		end
		$display("test compare-swap done");
	endtask
	task automatic test_remote();
		logic [31:0] old;
		logic ok;
		for (int s = 0; s < 4; s++) begin
			i_arcs_node_model.do_lock(arcs_pkg::arcs_sel_t'(2'(s)), 32'h10000000 + 32'(s),
				32'h30000000 + 32'(s), old, ok);
			chk({31'h0, ok}, 32'h00000001, "lock answered");
			chk(old, 32'h10000000 + 32'(s), "lock old value");
			wreg(`ARCS_OFF_CMPVAL, 32'h30000000 + 32'(s));
			wreg(`ARCS_OFF_NEWVAL, 32'h00000000);
			wreg(`ARCS_OFF_CTRL, 32'(s));
			rreg(`ARCS_OFF_NEWVAL, 32'h30000000 + 32'(s), "after lock");
		end
		$display("test remote lock done");
	endtask
	task automatic test_units();
		logic [3:0] codes [4] = '{4'h4, 4'h5, 4'h6, 4'hD};
		int lim;
		bus(1'b0, `ARCS_OFF_INTSTAT, 32'h00000000, 4'hF);
		chk({31'h0, rd[`ARCS_INT_SWAP]}, 32'h00000001, "swap event");
		wreg(`ARCS_OFF_INTSTAT, 32'h0000000F);
		wreg(`ARCS_OFF_INTMASK, 32'h0000000E);
		wreg(`ARCS_OFF_RETRY, 32'h00000123);
		for (int u = 0; u < 3; u++) begin
			lim = 3 - u;
			@(posedge coreClk);
			txStart[u] <= 1'b1;
			@(posedge coreClk);
			txStart[u] <= 1'b0;
			for (int k = 0; k <= lim + 1; k++) begin
				i_arcs_node_model.send_ack(u, codes[k % 4]);
				#1;
				chk({31'h0, txResend[u]}, 32'(k < lim), "resend");
				chk({31'h0, txGiveUp[u]}, 32'(k == lim), "give up");
			end
			@(posedge coreClk);
			txStart[u] <= 1'b1;
			@(posedge coreClk);
			txStart[u] <= 1'b0;
			i_arcs_node_model.send_ack(u, 4'h1);
			i_arcs_node_model.send_ack(u, 4'h4);
			#1;
			chk({29'h0, txResend | txGiveUp}, 32'h00000000, "no retry after other code");
		end
		repeat (3) @(posedge coreClk);
		chk({31'h0, irq}, 32'h00000001, "irq raised");
		rreg(`ARCS_OFF_INTSTAT, 32'h0000000E, "give-up status");
		wreg(`ARCS_OFF_INTSTAT, 32'h0000000E);
		repeat (3) @(posedge coreClk);
		chk({31'h0, irq}, 32'h00000000, "irq cleared");
		rreg(`ARCS_OFF_INTSTAT, 32'h00000000, "status cleared");
		$display("test transmit units done");
	endtask
	task automatic test_mid_reset();
		wreg(`ARCS_OFF_RETRY, 32'h00000FFF);
		@(posedge coreClk);
		rst <= 1'b1;
		repeat (4) @(posedge coreClk);
		rst <= 1'b0;
		rreg(`ARCS_OFF_RETRY, 32'h00000000, "retry after mid reset");
		rreg(`ARCS_OFF_CTRL, 32'h80000000, "control after mid reset");
		$display("test mid-run reset done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrapUp();
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge coreClk);
		rst <= 1'b0;
		test_reset();
		test_retry_reg();
		test_swap();
		test_remote();
		test_units();
		test_mid_reset();
		wrapUp();
	end
endmodule

// ### inc/arcs_consts.svh
// offsets, field positions, reset values and ack codes for the retry and compare-swap registers
`ifndef ARCS_CONSTS_SVH
`define ARCS_CONSTS_SVH
`define ARCS_ADDR_W 8
`define ARCS_OFF_RETRY 8'h08
`define ARCS_OFF_NEWVAL 8'h0C
`define ARCS_OFF_CMPVAL 8'h10
`define ARCS_OFF_CTRL 8'h14
`define ARCS_OFF_INTSTAT 8'h40
`define ARCS_OFF_INTMASK 8'h44
`define ARCS_RETRY_RW_MSB 11
`define ARCS_RETRY_RESET 12'h000
`define ARCS_PHYS_LSB 8
`define ARCS_ARSP_LSB 4
`define ARCS_AREQ_LSB 0
`define ARCS_DONE_BIT 31
`define ARCS_DONE_RESET 1'b1
`define ARCS_SEL_RESET 2'h0
`define ARCS_WORD_RESET 32'h00000000
`define ARCS_ACK_BUSY_X 4'h4
`define ARCS_ACK_BUSY_A 4'h5
`define ARCS_ACK_BUSY_B 4'h6
`define ARCS_ACK_DATA_ERR 4'hD
`define ARCS_NUM_UNITS 3
`define ARCS_INT_SWAP 0
`define ARCS_INT_W 4
`endif

// ### inc/arcs_pkg.sv
// types shared by the retry and compare-swap register bank
package arcs_pkg;
	typedef enum logic [1:0] {
		SEL_BUS_MANAGER = 2'b00,
		SEL_BANDWIDTH = 2'b01,
		SEL_CHAN_HI = 2'b10,
		SEL_CHAN_LO = 2'b11
	} arcs_sel_t;
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_HOST = 2'b01,
		SW_REMOTE = 2'b10
	} arcs_swap_state_t;
	typedef struct packed {
		logic valid;
		logic [3:0] code;
	} arcs_ack_t;
	typedef struct packed {
		logic valid;
		arcs_sel_t sel;
		logic [31:0] compare;
		logic [31:0] newValue;
	} arcs_lock_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] oldValue;
	} arcs_lock_rsp_t;
endpackage

// ### rtl/arcs_regs.sv
// retry-limit and compare-swap register bank behind an Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`include "arcs_consts.svh"

module arcs_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [`ARCS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// transmit units: new packet start and received ack
	input wire logic [`ARCS_NUM_UNITS-1:0] txStart,
	input wire arcs_pkg::arcs_ack_t [`ARCS_NUM_UNITS-1:0] txAck,
	output logic [`ARCS_NUM_UNITS-1:0] txResend,
	output logic [`ARCS_NUM_UNITS-1:0] txGiveUp,
	// remote lock requests from the serial bus
	input wire arcs_pkg::arcs_lock_req_t remoteLock,
	output arcs_pkg::arcs_lock_rsp_t remoteRsp,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic waitFf;
	logic [31:0] readDataFf;
	logic [`ARCS_RETRY_RW_MSB:0] retryFf;
	logic [31:0] newValFf;
	logic [31:0] cmpValFf;
	logic swapDoneFf;
	arcs_pkg::arcs_sel_t selFf;
	arcs_pkg::arcs_swap_state_t swapStateFf;
	logic [31:0] resourceFf [4];
	arcs_pkg::arcs_lock_rsp_t remoteRspFf;
	logic [`ARCS_INT_W-1:0] intStatFf;
	logic [`ARCS_INT_W-1:0] intMaskFf;
	logic irqFf;
	logic [3:0] retryCntFf [`ARCS_NUM_UNITS];
	logic [`ARCS_NUM_UNITS-1:0] unitActiveFf;
	logic [`ARCS_NUM_UNITS-1:0] resendFf;
	logic [`ARCS_NUM_UNITS-1:0] giveUpFf;

	logic wrTaken;
	logic rdTaken;
	logic wrCtrl;
	logic swapHit;
	logic [31:0] swapOld;
	logic swapEvent;
	logic [`ARCS_INT_W-1:0] intSet;
	logic [31:0] retryMerged;

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] byteMerge(input logic [31:0] oldW, input logic [31:0] newW,
		input logic [3:0] be);
		logic [31:0] res;
		res = oldW;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = newW[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic isRetryAck(input logic [3:0] code);
		return (code == `ARCS_ACK_BUSY_X) || (code == `ARCS_ACK_BUSY_A) ||
			(code == `ARCS_ACK_BUSY_B) || (code == `ARCS_ACK_DATA_ERR);
	endfunction

	function automatic logic [3:0] unitLimit(input logic [`ARCS_RETRY_RW_MSB:0] r,
		input int unit);
		logic [3:0] res;
		case (unit)
			0: res = r[`ARCS_AREQ_LSB +: 4];
			1: res = r[`ARCS_ARSP_LSB +: 4];
			default: res = r[`ARCS_PHYS_LSB +: 4];
		endcase
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake: waitrequest drops one cycle after a request, for one cycle
	assign wrTaken = avs_write && !waitFf;
	assign rdTaken = avs_read && !waitFf;
	assign wrCtrl = wrTaken && (avs_address == `ARCS_OFF_CTRL);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			waitFf <= 1'b1;
		end else if ((avs_read || avs_write) && waitFf) begin
			waitFf <= 1'b0;
		end else begin
			waitFf <= 1'b1;
		end
	end

	// read data loaded as waitrequest falls; unmapped reads return zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			readDataFf <= `ARCS_WORD_RESET;
		end else if (avs_read && waitFf) begin
			case (avs_address)
				`ARCS_OFF_RETRY: readDataFf <= {20'h00000, retryFf};
				`ARCS_OFF_NEWVAL: readDataFf <= newValFf;
				`ARCS_OFF_CMPVAL: readDataFf <= cmpValFf;
				`ARCS_OFF_CTRL: readDataFf <= {swapDoneFf, 29'h00000000, selFf};
				`ARCS_OFF_INTSTAT: readDataFf <= {28'h0000000, intStatFf};
				`ARCS_OFF_INTMASK: readDataFf <= {28'h0000000, intMaskFf};
				default: readDataFf <= `ARCS_WORD_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// retry limits
	assign retryMerged = byteMerge({20'h00000, retryFf}, avs_writedata, avs_byteenable);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			retryFf <= `ARCS_RETRY_RESET;
		end else if (wrTaken && avs_address == `ARCS_OFF_RETRY) begin
			retryFf <= retryMerged[`ARCS_RETRY_RW_MSB:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare-swap operand words
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmpValFf <= `ARCS_WORD_RESET;
		end else if (wrTaken && avs_address == `ARCS_OFF_CMPVAL) begin
			cmpValFf <= byteMerge(cmpValFf, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			newValFf <= `ARCS_WORD_RESET;
		end else if (swapStateFf == arcs_pkg::SW_HOST) begin
			newValFf <= swapOld;
		end else if (wrTaken && avs_address == `ARCS_OFF_NEWVAL) begin
			newValFf <= byteMerge(newValFf, avs_writedata, avs_byteenable);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare-swap engine
	assign swapOld = (swapStateFf == arcs_pkg::SW_HOST) ? resourceFf[selFf] :
		resourceFf[remoteLock.sel];
	assign swapHit = (swapStateFf == arcs_pkg::SW_HOST) ? (swapOld == cmpValFf) :
		(swapOld == remoteLock.compare);
	assign swapEvent = (swapStateFf == arcs_pkg::SW_HOST);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			selFf <= arcs_pkg::arcs_sel_t'(`ARCS_SEL_RESET);
		end else if (wrCtrl && avs_byteenable[0]) begin
			selFf <= arcs_pkg::arcs_sel_t'(avs_writedata[1:0]);
		end
	end

	// host swap starts on a control write; remote locks run when the host is idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			swapStateFf <= arcs_pkg::SW_IDLE;
		end else begin
			case (swapStateFf)
				arcs_pkg::SW_IDLE: begin
					if (wrCtrl) begin
						swapStateFf <= arcs_pkg::SW_HOST;
					end else if (remoteLock.valid && !remoteRspFf.ack) begin
						swapStateFf <= arcs_pkg::SW_REMOTE;
					end
				end
				arcs_pkg::SW_HOST: swapStateFf <= arcs_pkg::SW_IDLE;
				arcs_pkg::SW_REMOTE: swapStateFf <= wrCtrl ? arcs_pkg::SW_HOST : arcs_pkg::SW_IDLE;
				default: swapStateFf <= arcs_pkg::SW_IDLE;
			endcase
		end
	end

	generate
		for (genvar r = 0; r < 4; r++) begin : g_res
			always_ff @(posedge core_clk) begin
				if (rst) begin
					resourceFf[r] <= `ARCS_WORD_RESET;
				end else if (swapHit && swapStateFf == arcs_pkg::SW_HOST && selFf == r) begin
					resourceFf[r] <= newValFf;
				end else if (swapHit && swapStateFf == arcs_pkg::SW_REMOTE &&
					remoteLock.sel == r) begin
					resourceFf[r] <= remoteLock.newValue;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			remoteRspFf <= '0;
		end else if (swapStateFf == arcs_pkg::SW_REMOTE) begin
			remoteRspFf.ack <= 1'b1;
			remoteRspFf.oldValue <= swapOld;
		end else begin
			remoteRspFf.ack <= 1'b0;
		end
	end

	// completion flag: finishing host swap sets it, control write clears it, set wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			swapDoneFf <= `ARCS_DONE_RESET;
		end else if (swapEvent) begin
			swapDoneFf <= 1'b1;
		end else if (wrCtrl) begin
			swapDoneFf <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit retry counters: unit 0 request, 1 response, 2 physical response
	generate
		for (genvar u = 0; u < `ARCS_NUM_UNITS; u++) begin : g_unit
			always_ff @(posedge core_clk) begin
				if (rst) begin
					retryCntFf[u] <= 4'h0;
					unitActiveFf[u] <= 1'b0;
					resendFf[u] <= 1'b0;
					giveUpFf[u] <= 1'b0;
				end else begin
					resendFf[u] <= 1'b0;
					giveUpFf[u] <= 1'b0;
					if (txStart[u]) begin
						retryCntFf[u] <= 4'h0;
						unitActiveFf[u] <= 1'b1;
					end else if (txAck[u].valid && unitActiveFf[u]) begin
						if (!isRetryAck(txAck[u].code)) begin
							unitActiveFf[u] <= 1'b0;
						end else if (retryCntFf[u] < unitLimit(retryFf, u)) begin
							retryCntFf[u] <= retryCntFf[u] + 4'h1;
							resendFf[u] <= 1'b1;
						end else begin
							unitActiveFf[u] <= 1'b0;
							giveUpFf[u] <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, mask and output
	assign intSet = {giveUpFf, swapEvent};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			intStatFf <= '0;
		end else if (wrTaken && avs_address == `ARCS_OFF_INTSTAT) begin
			intStatFf <= (intStatFf & ~avs_writedata[`ARCS_INT_W-1:0]) | intSet;
		end else begin
			intStatFf <= intStatFf | intSet;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			intMaskFf <= '0;
		end else if (wrTaken && avs_address == `ARCS_OFF_INTMASK) begin
			intMaskFf <= avs_writedata[`ARCS_INT_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irqFf <= 1'b0;
		end else begin
			irqFf <= |(intStatFf & intMaskFf);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign avs_waitrequest = waitFf;
	assign avs_readdata = readDataFf;
	assign txResend = resendFf;
	assign txGiveUp = giveUpFf;
	assign remoteRsp = remoteRspFf;
	assign irq = irqFf;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	property p_retry_high_zero;
		@(posedge core_clk) disable iff (rst)
		(avs_read && waitFf && avs_address == `ARCS_OFF_RETRY) |=>
			(readDataFf[31:29] == 3'h0) && !waitFf;
	endproperty
	a_retry_high_zero: assert property (p_retry_high_zero) else $error("retry top bits nonzero");

	property p_retry_cycle_zero;
		@(posedge core_clk) disable iff (rst)
		(avs_read && waitFf && avs_address == `ARCS_OFF_RETRY) |=> readDataFf[28:12] == 17'h00000;
	endproperty
	a_retry_cycle_zero: assert property (p_retry_cycle_zero) else $error("retry mid bits nonzero");

	property p_retry_write;
		@(posedge core_clk) disable iff (rst)
		(wrTaken && avs_address == `ARCS_OFF_RETRY && avs_byteenable[1:0] == 2'h3) |=>
			retryFf == $past(avs_writedata[11:0]);
	endproperty
	a_retry_write: assert property (p_retry_write) else $error("retry field not written");

	property p_ctrl_reserved;
		@(posedge core_clk) disable iff (rst)
		(avs_read && waitFf && avs_address == `ARCS_OFF_CTRL) |=>
			readDataFf[30:2] == 29'h00000000 && readDataFf[31] == $past(swapDoneFf);
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("control reserved bits nonzero");

	property p_done_cycle;
		@(posedge core_clk) disable iff (rst)
		(wrCtrl && swapStateFf == arcs_pkg::SW_IDLE) |=> !swapDoneFf ##1 swapDoneFf;
	endproperty
	a_done_cycle: assert property (p_done_cycle) else $error("completion flag sequence wrong");

	property p_done_set;
		@(posedge core_clk) disable iff (rst)
		(swapStateFf == arcs_pkg::SW_HOST) |=> swapDoneFf && newValFf == $past(swapOld);
	endproperty
	a_done_set: assert property (p_done_set) else $error("swap finish not flagged");

	property p_swap_hit;
		@(posedge core_clk) disable iff (rst)
		(swapStateFf == arcs_pkg::SW_HOST && resourceFf[selFf] == cmpValFf) |=>
			resourceFf[$past(selFf)] == $past(newValFf);
	endproperty
	a_swap_hit: assert property (p_swap_hit) else $error("resource not swapped");

	property p_swap_miss;
		@(posedge core_clk) disable iff (rst)
		(swapStateFf == arcs_pkg::SW_HOST && resourceFf[selFf] != cmpValFf) |=>
			resourceFf[$past(selFf)] == $past(resourceFf[selFf]);
	endproperty
	a_swap_miss: assert property (p_swap_miss) else $error("resource changed on miss");

	property p_retry_resend;
		@(posedge core_clk) disable iff (rst)
		(!txStart[0] && txAck[0].valid && unitActiveFf[0] && isRetryAck(txAck[0].code) &&
			retryCntFf[0] < retryFf[3:0]) |=> resendFf[0] && !giveUpFf[0];
	endproperty
	a_retry_resend: assert property (p_retry_resend) else $error("retry not issued");

	property p_retry_stop;
		@(posedge core_clk) disable iff (rst)
		(!txStart[2] && txAck[2].valid && unitActiveFf[2] &&
			retryCntFf[2] >= retryFf[11:8]) |=> !resendFf[2] && !unitActiveFf[2];
	endproperty
	a_retry_stop: assert property (p_retry_stop) else $error("retry past limit");
endmodule
